// File: host_port_pkg.sv
package host_port_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;

  // ---------------------------------------------------------------
  // address window
  // ---------------------------------------------------------------
  localparam logic [16:0] MEM_FIRST = 17'h00000;
  localparam logic [16:0] MEM_LAST  = 17'h13fff;
  localparam logic [16:0] REG_FIRST = 17'h1ffe0;
  localparam logic [16:0] REG_LAST  = 17'h1ffff;

  // ---------------------------------------------------------------
  // strap values
  // ---------------------------------------------------------------
  localparam logic [2:0] IFSEL_GENERIC  = 3'h7;
  localparam logic       SCHEME_ONE     = 1'h0;
  localparam logic       SCHEME_TWO     = 1'h1;
  localparam logic       ENDIAN_LITTLE  = 1'h0;
  localparam logic       ENDIAN_BIG     = 1'h1;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [4:0]  STROBES_IDLE   = 5'h1f;
  localparam logic [2:0]  IFSEL_RESET    = 3'h0;
  localparam logic [15:0] DATA_RESET     = 16'h0000;
  localparam logic [16:0] ADDR_RESET     = 17'h00000;

  // ---------------------------------------------------------------
  // port sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ  = 2'b01,
    ST_DONE = 2'b10
  } port_state_e;

endpackage

// File: strobe_sync.sv
`timescale 1ns/10ps

module strobe_sync #(
  parameter int                WIDTH     = 5,
  parameter logic [WIDTH-1:0]  RESET_VAL = '1
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // raw and filtered levels
  input  wire logic [WIDTH-1:0] raw_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;
  wire  [WIDTH-1:0] agree = ~(stage2_q ^ stage3_q);

  // -------------------------------------------------------------
  // three stages, a change counts once stages two and three agree
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stage1_q  <= RESET_VAL;
      stage2_q  <= RESET_VAL;
      stage3_q  <= RESET_VAL;
      level_out <= RESET_VAL;
    end else begin
      stage1_q  <= raw_in;
      stage2_q  <= stage1_q;
      stage3_q  <= stage2_q;
      level_out <= (agree & stage3_q) | (~agree & level_out);
    end
  end

endmodule // strobe_sync

// File: host_bus_port.sv
`timescale 1ns/10ps

// Function
// RL1: sixteen-bit data port with separately strobed low and high byte lanes.
// RL2: scheme one uses chip select plus per-lane read and write strobes.
// RL3: scheme two uses high-byte enable plus shared read and write strobes.
// RL4: scheme one writes store only lanes whose write strobe is low.
// RL5: scheme one reads return data on lanes whose read strobe is low.
// RL6: scheme two includes the high lane only while high-byte enable is low.
// RL7: scheme two captures write data while write strobe and chip select assert.
// RL8: scheme two drives read data onto the bus during the read strobe.
// RL9: hold-off stays low until read data valid or write data accepted.
// RL10: port logic runs on the host bus clock, not the display clock.
// RL11: host strobes are asynchronous and pass synchronisers before use; the hold-off output and the read drive enable use the raw strobes.
// RL12: bus-mode strap low selects scheme one, high scheme two, latched.
// RL13: endian strap latched at reset, high big-endian, low little-endian.
// RL14: interface-select straps latched, 111 enables the generic scheme family.
// RL15: scheme two ignores the high-byte read strobe input, tied high.
// RL16: only a 128K byte window decodes, repeating above it.
// RL17: offsets zero through 13fff reach display memory.
// RL18: offsets 1ffe0 through 1ffff reach control registers.
// RL19: host glue decodes high address lines into the chip select.
// RL20: access starts on chip select plus strobe, ends on strobe release.
module host_bus_port (
  // host port clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // straps
  input  wire logic        bus_mode_strap,
  input  wire logic        endian_strap,
  input  wire logic [2:0]  interface_select_straps,
  // host control pins
  input  wire logic        chip_sel_n,
  input  wire logic        low_write_strobe_n,
  input  wire logic        high_lane_strobe_n,
  input  wire logic        read_strobe_n,
  input  wire logic        high_read_strobe_n,
  output logic             hold_off_n,
  // host address and data pins
  input  wire logic [16:0] host_addr_in,
  input  wire logic [15:0] host_data_in,
  output logic      [15:0] host_data_out,
  output logic      [15:0] host_data_oe,
  // internal memory and register access
  output logic             int_req,
  output logic             int_reg_sel,
  output logic             int_we,
  output logic      [15:0] int_addr,
  output logic      [1:0]  int_be,
  output logic      [15:0] int_wdata,
  input  wire logic        int_ack,
  input  wire logic [15:0] int_rdata
);

  // ---------------------------------------------------------------
  // straps
  // ---------------------------------------------------------------
  logic       mode_q;
  logic       endian_q;
  logic [2:0] ifsel_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mode_q   <= bus_mode_strap;          // [RL12]
      endian_q <= endian_strap;            // [RL13]
      ifsel_q  <= interface_select_straps; // [RL14]
    end
  end

  wire port_en = (ifsel_q == host_port_pkg::IFSEL_GENERIC); // [RL14]
  wire scheme2 = (mode_q == host_port_pkg::SCHEME_TWO);     // [RL12]

  // ---------------------------------------------------------------
  // strobe synchronisers
  // ---------------------------------------------------------------
  logic [4:0] strb_s;

  // host strobes sampled on the host port clock [RL10] [RL11]
  strobe_sync #(
    .WIDTH     (5),
    .RESET_VAL (host_port_pkg::STROBES_IDLE)
  ) u_sync (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .raw_in    ({chip_sel_n, low_write_strobe_n, high_lane_strobe_n, read_strobe_n, high_read_strobe_n}),
    .level_out (strb_s)
  );

  // ---------------------------------------------------------------
  // lane decode
  // ---------------------------------------------------------------
  wire       cs_s   = ~strb_s[4];
  wire       wr0_s  = ~strb_s[3];
  wire       wr1_s  = ~strb_s[2];
  wire       rd0_s  = ~strb_s[1];
  wire       rd1_s  = ~strb_s[0];
  wire       lo_adr = ~host_addr_in[0];
  // scheme two: high lane follows the byte enable, low lane follows the address [RL3] [RL6]
  wire [1:0] s2_lanes = {wr1_s, lo_adr};
  // scheme two never looks at the high read strobe [RL15]
  wire [1:0] wr_lanes = scheme2 ? (s2_lanes & {2{wr0_s}}) : {wr1_s, wr0_s}; // [RL2] [RL4] [RL7]
  wire [1:0] rd_lanes = scheme2 ? (s2_lanes & {2{rd0_s}}) : {rd1_s, rd0_s}; // [RL2] [RL5] [RL8]
  wire       any_wr   = |wr_lanes;
  wire       any_rd   = |rd_lanes;
  wire       active_s = cs_s & (any_wr | any_rd);

  // raw strobe view for the hold-off output
  wire raw_s1  = ~low_write_strobe_n | ~high_lane_strobe_n | ~read_strobe_n | ~high_read_strobe_n;
  wire raw_s2  = ~low_write_strobe_n | ~read_strobe_n;
  wire raw_act = ~chip_sel_n & (scheme2 ? raw_s2 : raw_s1);

  // ---------------------------------------------------------------
  // address window decode
  // ---------------------------------------------------------------
  // only 17 address bits enter, so the window repeats every 128K [RL16]
  wire in_mem = (host_addr_in <= host_port_pkg::MEM_LAST);  // [RL17]
  wire in_reg = (host_addr_in >= host_port_pkg::REG_FIRST); // [RL18]
  wire mapped = in_mem | in_reg;

  // byte order: big-endian swaps the lanes on the way in and out
  wire [15:0] wdata_sw = endian_q ? {host_data_in[7:0], host_data_in[15:8]} : host_data_in; // [RL13]
  wire [15:0] rdata_sw = endian_q ? {int_rdata[7:0], int_rdata[15:8]} : int_rdata;          // [RL13]
  wire [1:0]  lane_sel = any_wr ? wr_lanes : rd_lanes;
  wire [1:0]  be_sw    = endian_q ? {lane_sel[0], lane_sel[1]} : lane_sel;

  // ---------------------------------------------------------------
  // port sequencer
  // ---------------------------------------------------------------
  host_port_pkg::port_state_e state_q;
  host_port_pkg::port_state_e state_d;
  logic [1:0] lanes_q;
  logic       drive_q;

  wire start    = port_en & active_s;    // [RL19] [RL20]
  wire strb_off = ~active_s;             // [RL20]

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      host_port_pkg::ST_IDLE: begin
        if (start) begin
          state_d = mapped ? host_port_pkg::ST_REQ : host_port_pkg::ST_DONE;
        end
      end
      host_port_pkg::ST_REQ: begin
        if (int_ack) begin
          state_d = host_port_pkg::ST_DONE;
        end
      end
      host_port_pkg::ST_DONE: begin
        if (strb_off) begin
          state_d = host_port_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = host_port_pkg::ST_IDLE;
      end
    endcase
  end

  wire idle_st = (state_q == host_port_pkg::ST_IDLE);
  wire req_st  = (state_q == host_port_pkg::ST_REQ);
  wire done_st = (state_q == host_port_pkg::ST_DONE);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= host_port_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // request capture, only strobed bytes are enabled [RL4] [RL6] [RL7]
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      int_req     <= 1'b0;
      int_reg_sel <= 1'b0;
      int_we      <= 1'b0;
      int_addr    <= host_port_pkg::ADDR_RESET[16:1];
      int_be      <= 2'h0;
      int_wdata   <= host_port_pkg::DATA_RESET;
      lanes_q     <= 2'h0;
    end else if (idle_st & start) begin
      int_req     <= mapped;
      int_reg_sel <= in_reg;
      int_we      <= any_wr;
      int_addr    <= host_addr_in[16:1];
      int_be      <= be_sw;
      int_wdata   <= wdata_sw;
      lanes_q     <= lane_sel;
    end else if (req_st & int_ack) begin
      int_req     <= 1'b0;
    end
  end

  // read data held for the host until the strobe drops [RL5] [RL8]
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      host_data_out <= host_port_pkg::DATA_RESET;
      drive_q       <= 1'b0;
    end else if (req_st & int_ack & ~int_we) begin
      host_data_out <= rdata_sw;
      drive_q       <= 1'b1;
    end else if (idle_st & start & ~mapped & ~any_wr) begin
      host_data_out <= host_port_pkg::DATA_RESET;
      drive_q       <= 1'b1;
    end else if (done_st & strb_off) begin
      drive_q       <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // pin outputs
  // ---------------------------------------------------------------
  wire       rd_raw  = ~chip_sel_n & ~read_strobe_n;
  wire       rd_hold = scheme2 ? rd_raw : (~chip_sel_n & (~read_strobe_n | ~high_read_strobe_n));
  wire       drive   = drive_q & done_st & rd_hold;
  wire [1:0] oe_lane = lanes_q & {2{drive}};

  // bus driven only on strobed lanes, during the read strobe [RL1] [RL5] [RL8]
  assign host_data_oe = {{host_port_pkg::LANE_W{oe_lane[1]}}, {host_port_pkg::LANE_W{oe_lane[0]}}};
  // hold the host off until data is ready or accepted [RL9]
  assign hold_off_n   = ~(port_en & raw_act & ~done_st);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_grant;
    req_st && int_ack;
  endsequence

  sequence s_held;
    done_st && hold_off_n;
  endsequence

  a_strap_stable: assert property ($stable(mode_q) && $stable(ifsel_q)) // [RL12]
    else $error("strap latch changed outside reset");

  a_endian_latch: assert property ($fell(sys_rst) |-> endian_q == $past(endian_strap)) // [RL13]
    else $error("endian strap not latched at reset");

  a_ifsel_gate: assert property (!port_en |-> idle_st && hold_off_n && host_data_oe == 16'h0000) // [RL14]
    else $error("port active without generic strap value");

  a_start_cause: assert property ($rose(int_req) |-> $past(cs_s) && $past(any_wr || any_rd)) // [RL20]
    else $error("request without synchronised chip select and strobe");

  a_window_map: assert property (int_req |-> (int_reg_sel ? {int_addr, 1'b1} >= host_port_pkg::REG_FIRST
                                 : {int_addr, 1'b0} <= host_port_pkg::MEM_LAST)) // [RL16]
    else $error("request outside decoded window");

  a_hold_wait: assert property (req_st && raw_act |-> !hold_off_n) // [RL9]
    else $error("hold-off released before grant");

  a_grant_release: assert property (s_grant |=> s_held or (done_st && !raw_act)) // [RL9]
    else $error("hold-off not released after grant");

  a_read_drive: assert property (host_data_oe != 16'h0000 |-> done_st && !int_we && rd_hold) // [RL8]
    else $error("data driven outside read strobe");

  a_write_lanes: assert property ($rose(int_req) && int_we && !scheme2 && !endian_q
                                  |-> int_be == {$past(wr1_s), $past(wr0_s)}) // [RL4]
    else $error("write lanes differ from strobes");

  a_release_end: assert property (done_st && strb_off |=> idle_st ##1 !int_req) // [RL20]
    else $error("access did not end on strobe release");

endmodule // host_bus_port

// File: host_model.sv
`timescale 1ns/10ps

module host_model (
  // link side
  input  wire logic        hclk,
  input  wire logic        scheme,
  input  wire logic        hold_off_n,
  input  wire logic [15:0] bus_w,
  // host pins
  output logic             chip_sel_n,
  output logic             low_write_strobe_n,
  output logic             high_lane_strobe_n,
  output logic             read_strobe_n,
  output logic             high_read_strobe_n,
  output logic      [16:0] host_addr_in,
  output logic      [15:0] host_drv
);
  initial begin
    {chip_sel_n, low_write_strobe_n, high_lane_strobe_n} = 3'h7;
    {read_strobe_n, high_read_strobe_n} = 2'h3;
    host_addr_in = 17'h00000;
    host_drv = 16'h0000;
  end

  // ----------------------------------------
  // one access, held while hold-off is low
  // ----------------------------------------
  task automatic xfer(input logic we, input logic [16:0] a, input logic [1:0] ln, input logic [15:0] wd,
                      output logic [15:0] rd, output logic held, output logic tmo);
    int i;
    @(posedge hclk);
    #1;
    host_addr_in = a;
    chip_sel_n = 1'b0;
    if (we) host_drv = wd;
    if (scheme) begin
      high_lane_strobe_n = ~ln[1];
      low_write_strobe_n = ~we;
      read_strobe_n = we;
    end else begin
      low_write_strobe_n = ~(we & ln[0]);
      high_lane_strobe_n = ~(we & ln[1]);
      read_strobe_n = ~(!we & ln[0]);
      high_read_strobe_n = ~(!we & ln[1]);
    end
    #5;
    held = ~hold_off_n;
    for (i = 0; i < 40 && hold_off_n !== 1'b1; i++) @(posedge hclk);
    tmo = (i == 40);
    rd = bus_w;
    #1;
    {chip_sel_n, low_write_strobe_n, high_lane_strobe_n} = 3'h7;
    {read_strobe_n, high_read_strobe_n} = 2'h3;
    host_addr_in = ~a;
    host_drv = ~host_drv;
    repeat (2) @(posedge hclk);
  endtask
endmodule // host_model

// File: testbench.sv
`timescale 1ns/10ps

module testbench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        ref_clk, sys_rst, hclk, bus_mode_strap, endian_strap;
  logic [2:0]  interface_select_straps;
  logic        chip_sel_n, low_write_strobe_n, high_lane_strobe_n;
  logic        read_strobe_n, high_read_strobe_n, hold_off_n;
  logic [16:0] host_addr_in;
  logic [15:0] host_drv, bus_w, host_data_out, host_data_oe;
  logic        int_req, int_reg_sel, int_we, int_ack;
  logic [15:0] int_addr, int_wdata, int_rdata, lfsr_q, exp_addr, exp_wd;
  logic [1:0]  int_be, exp_be;
  logic        exp_req, exp_we, exp_sel;
  logic [15:0] mem [logic [16:0]];
  int          n_mismatch, samples_checked;

  assign bus_w = (host_data_oe & host_data_out) | (~host_data_oe & host_drv);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    hclk = 1'b0;
    #137;
    forever #200 hclk = ~hclk;
  end

  host_bus_port DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_mode_strap(bus_mode_strap),
    .endian_strap(endian_strap), .interface_select_straps(interface_select_straps), .chip_sel_n(chip_sel_n),
    .low_write_strobe_n(low_write_strobe_n), .high_lane_strobe_n(high_lane_strobe_n),
    .read_strobe_n(read_strobe_n), .high_read_strobe_n(high_read_strobe_n), .hold_off_n(hold_off_n),
    .host_addr_in(host_addr_in), .host_data_in(bus_w), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .int_req(int_req), .int_reg_sel(int_reg_sel), .int_we(int_we),
    .int_addr(int_addr), .int_be(int_be), .int_wdata(int_wdata), .int_ack(int_ack), .int_rdata(int_rdata));

  host_model hm (.hclk(hclk), .scheme(bus_mode_strap), .hold_off_n(hold_off_n), .bus_w(bus_w),
    .chip_sel_n(chip_sel_n), .low_write_strobe_n(low_write_strobe_n), .high_lane_strobe_n(high_lane_strobe_n),
    .read_strobe_n(read_strobe_n), .high_read_strobe_n(high_read_strobe_n), .host_addr_in(host_addr_in),
    .host_drv(host_drv));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [15:0] swap(input logic [15:0] v);
    return {v[7:0], v[15:8]};
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic do_reset(input logic [2:0] sel, input logic s, input logic e);
    @(posedge ref_clk);
    #1;
    sys_rst = 1'b1;
    interface_select_straps = sel;
    bus_mode_strap = s;
    endian_strap = e;
    repeat (5) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
  endtask

  // ----------------------------------------
  // one host access against the model
  // ----------------------------------------
  task automatic run(input logic we, input logic [16:0] a, input logic [1:0] ln);
    logic [15:0] rd, d, m, lm, bm;
    logic        held, tmo, on;
    lfsr_q = lfsr(lfsr_q);
    d = lfsr_q;
    on = (interface_select_straps == 3'h7);
    exp_sel = (a >= 17'h1ffe0);
    exp_req = on && (a <= 17'h13fff || exp_sel);
    exp_we = we;
    exp_addr = a[16:1];
    exp_be = endian_strap ? {ln[0], ln[1]} : ln;
    exp_wd = endian_strap ? swap(d) : d;
    lm = {{8{ln[1]}}, {8{ln[0]}}};
    bm = {{8{exp_be[1]}}, {8{exp_be[0]}}};
    m = (exp_req && mem.exists({exp_sel, exp_addr})) ? mem[{exp_sel, exp_addr}] : 16'h0000;
    hm.xfer(we, a, ln, d, rd, held, tmo);
    chk("hold_off_low", {16'h0000, on}, {16'h0000, held});
    chk("timeout", 17'h00000, {16'h0000, tmo});
    if (tmo) finish_test();
    if (!we && on) chk("rdata", {1'b0, (endian_strap ? swap(m) : m) & lm}, {1'b0, rd & lm});
    if (we && exp_req) mem[{exp_sel, exp_addr}] = (m & ~bm) | (exp_wd & bm);
  endtask

  // ----------------------------------------
  // internal memory responder
  // ----------------------------------------
  initial begin
    int_ack = 1'b0;
    int_rdata = 16'h0000;
    forever begin
      @(posedge ref_clk);
      #2;
      if (int_req === 1'b1) begin
        chk("int_req", {16'h0000, exp_req}, 17'h00001);
        chk("int_we", {16'h0000, exp_we}, {16'h0000, int_we});
        chk("int_reg_sel", {16'h0000, exp_sel}, {16'h0000, int_reg_sel});
        chk("int_addr", {1'b0, exp_addr}, {1'b0, int_addr});
        chk("int_be", {15'h0000, exp_be}, {15'h0000, int_be});
        if (exp_we) chk("int_wdata", {1'b0, exp_wd}, {1'b0, int_wdata});
        repeat (lfsr_q[2:0]) @(posedge ref_clk);
        #1;
        int_rdata = mem.exists({int_reg_sel, int_addr}) ? mem[{int_reg_sel, int_addr}] : 16'h0000;
        int_ack = 1'b1;
        @(posedge ref_clk);
        #1;
        int_ack = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [16:0] a;
    logic [16:0] edges [5];
    logic [1:0]  ln;
    edges = '{17'h13ffe, 17'h14000, 17'h1ffde, 17'h1ffe0, 17'h1fffe};
    n_mismatch = 0;
    samples_checked = 0;
    lfsr_q = 16'h0028;
    sys_rst = 1'b1;
    {interface_select_straps, bus_mode_strap, endian_strap} = 5'h1c;
    for (int c = 0; c < 5; c++) begin
      do_reset((c == 4) ? 3'h3 : 3'h7, c[0], c[1]);
      for (int l = 1; l < 4; l++) begin
        ln = l[1:0];
        lfsr_q = lfsr(lfsr_q);
        a = {3'h0, lfsr_q[13:1], ~ln[0]};
        run(1'b1, a, ln);
        run(1'b0, a, ln);
      end
      for (int k = 0; k < 5; k++) begin
        run(1'b1, edges[k], 2'h3);
        run(1'b0, edges[k], 2'h3);
      end
    end
    finish_test();
  end
endmodule // testbench
